/* logic/ccw_pkg.sv */
package ccw_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM slave)
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_CW0 = 5'h00;
  localparam logic [4:0] ADDR_MASK = 5'h04;
  localparam logic [4:0] ADDR_FRAME_ADDR = 5'h08;
  localparam logic [4:0] ADDR_FRAME_DATA = 5'h0c;
  localparam logic [4:0] ADDR_WORD_CNT = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // ----------------------------------------------------------------
  // Control word zero layout and values after reset
  // ----------------------------------------------------------------
  typedef struct packed {
    logic key_source_select;
    logic internal_port_select;
    logic [16:0] rsvd_29_13;
    logic overheat_shutdown_enable;
    logic rsvd_11;
    logic fallback_disable;
    logic rsvd_9;
    logic readback_cell_mask_n;
    logic frame_addr_view_select;
    logic decryptor_enable;
    logic [1:0] security_level;
    logic keep_config_port;
    logic [1:0] rsvd_2_1;
    logic user_global_tristate_n;
  } ccw_cw0_t;

  localparam logic [31:0] CW0_WRITABLE = 32'hc00015f9;
  localparam logic [31:0] CW0_RESET = 32'h00000101;
  localparam logic [31:0] MASK_RESET = 32'hffffffff;
  localparam logic [23:0] FRAME_ADDR_RESET = 24'h000000;
  localparam logic [31:0] WORD_CNT_RESET = 32'h00000000;
  localparam logic [1:0] LEVEL_OPEN = 2'h0;
  localparam logic [1:0] LEVEL_NO_READ = 2'h1;

  // Status word field positions
  localparam int STAT_KEY_POS = 0;
  localparam int STAT_LEVEL_POS = 1;
  localparam int STAT_OVERHEAT_POS = 3;
  localparam int STAT_CFG_TRI_POS = 4;
  localparam int STAT_REFUSED_POS = 5;

  // Qualifiers that travel with each bus access
  typedef struct packed {
    logic internal_port;
    logic encrypted;
  } ccw_access_t;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } ccw_bus_state_t;

  localparam int SYNC_BITS = 2;

endpackage : ccw_pkg

/* logic/ccw_sync.sv */
`timescale 1ns/1ps
module ccw_sync #(
  parameter int W = 2
) (
  // Clock
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ----------------------------------------------------------------
  // Two stages per bit; the first stage feeds only the second
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else if (ce_i) begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;

endmodule : ccw_sync

/* logic/ccw_masked_merge.sv */
`timescale 1ns/1ps
module ccw_masked_merge #(
  parameter int W = 32
) (
  // Inputs
  input wire logic [W-1:0] old_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [W-1:0] mask_i,
  input wire logic [W-1:0] writable_i,
  // Result
  output logic [W-1:0] merged_o
);

  // ----------------------------------------------------------------
  // Per bit: take new data only where masked in and not reserved
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign merged_o[g] = writable_i[g] &
        ((mask_i[g] & wdata_i[g]) | (~mask_i[g] & old_i[g]));
    end
  endgenerate

endmodule : ccw_masked_merge

/* logic/ccw_control_word.sv */
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
// What this block does
// - Every control write passes the bit-update mask
// - Bit 31 picks key: RAM default, fuse
// - Key source frozen once decryptor is enabled
// - Bit 30 picks top or bottom internal port
// - Bit 12 lets over-temperature alarm power down
// - Bit 10 set stops on failure, no fallback
// - Bit 8 low masks changeable cell readback
// - Bit 7 picks ECC or CRC frame address
// - Bit 6 enables the decryptor
// - Bits 5:4 security: open, no read, locked
// - Security applies to external port only
// - New level acts after stream end or startup
// - External encrypted writes only to frame address/data
// - Bit 3 keeps mode-pin config port alive
// - Bit 0 low tri-states all user I/O
// - Both tri-states asserted turn pull-ups off
// - Decrypt word count readable only when decryptor off
module ccw_control_word (
  // Clock, reset, enable
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Access qualifiers from the packet front end
  input wire logic CFG_SRC_INTERNAL_I,
  input wire logic CFG_ENCRYPTED_I,
  // Configuration sequencing events
  input wire logic END_OF_STARTUP_I,
  input wire logic ENC_STREAM_END_I,
  // Frame address sources
  input wire logic [23:0] ECC_ERROR_FRAME_ADDR_I,
  input wire logic [23:0] READBACK_CRC_ADDR_I,
  // Pins
  input wire logic OVERHEAT_ALARM_I,
  input wire logic CFG_GLOBAL_TRISTATE_N_I,
  // Control outputs
  output logic KEY_SOURCE_SELECT_O,
  output logic INTERNAL_PORT_SELECT_O,
  output logic OVERHEAT_POWER_DOWN_O,
  output logic FALLBACK_DISABLE_O,
  output logic READBACK_CELL_MASK_N_O,
  output logic [23:0] FRAME_ADDR_VIEW_O,
  output logic DECRYPTOR_ENABLE_O,
  output logic [1:0] SECURITY_LEVEL_O,
  output logic KEEP_CONFIG_PORT_O,
  output logic USER_GLOBAL_TRISTATE_N_O,
  output logic PULLUP_OFF_O,
  // Frame data path
  output logic [31:0] FRAME_DATA_O,
  output logic FRAME_DATA_VALID_O
);

  ccw_pkg::ccw_cw0_t cw0_r;
  ccw_pkg::ccw_cw0_t cw0_nxt;
  ccw_pkg::ccw_access_t acc;
  ccw_pkg::ccw_bus_state_t bus_r;
  logic [31:0] mask_r;
  logic [23:0] frame_addr_r;
  logic [31:0] word_cnt_r;
  logic key_eff_r;
  logic [1:0] level_eff_r;
  logic eos_prev_r;
  logic refused_r;
  logic waitreq_r;
  logic [31:0] rdata_r;
  logic [31:0] fdata_r;
  logic fvalid_r;
  logic [1:0] pins_sync;
  logic overheat_s;
  logic cfg_tri_n_s;
  logic take;
  logic ext;
  logic rd_block;
  logic wr_block;
  logic wr_ok;
  logic [31:0] lane_mask;
  logic [31:0] eff_mask;
  logic load_level;
  logic [31:0] status_word;
  logic [31:0] rd_value;

  // ----------------------------------------------------------------
  // Pin synchronisers and masked merge
  // ----------------------------------------------------------------
  ccw_sync #(
    .W(ccw_pkg::SYNC_BITS)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .async_i({OVERHEAT_ALARM_I, CFG_GLOBAL_TRISTATE_N_I}),
    .sync_o(pins_sync)
  );
  assign overheat_s = pins_sync[1];
  assign cfg_tri_n_s = pins_sync[0];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign lane_mask[8*g +: 8] = {8{AVS_BYTEENABLE_I[g]}};
    end
  endgenerate
  assign eff_mask = mask_r & lane_mask;

  ccw_masked_merge #(
    .W(32)
  ) u_merge (
    .old_i(cw0_r),
    .wdata_i(AVS_WRITEDATA_I),
    .mask_i(eff_mask),
    .writable_i(ccw_pkg::CW0_WRITABLE),
    .merged_o(cw0_nxt)
  );

  // ----------------------------------------------------------------
  // Access qualification
  // ----------------------------------------------------------------
  assign acc = '{internal_port: CFG_SRC_INTERNAL_I, encrypted: CFG_ENCRYPTED_I};
  assign take = CE_I & (AVS_READ_I | AVS_WRITE_I) & (bus_r == ccw_pkg::BUS_IDLE);
  assign ext = ~acc.internal_port;
  assign rd_block = ext & (level_eff_r != ccw_pkg::LEVEL_OPEN);
  // Locked level stops all external writes; below it encrypted data may
  // reach only the frame address and frame data registers.
  assign wr_block = ext & (level_eff_r[1] | (acc.encrypted &
    (AVS_ADDRESS_I != ccw_pkg::ADDR_FRAME_ADDR) &
    (AVS_ADDRESS_I != ccw_pkg::ADDR_FRAME_DATA)));
  assign wr_ok = take & AVS_WRITE_I & ~wr_block;
  assign load_level = cw0_r.decryptor_enable ? ENC_STREAM_END_I :
    (END_OF_STARTUP_I & ~eos_prev_r);

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then one answer cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      bus_r <= ccw_pkg::BUS_IDLE;
      waitreq_r <= 1'b1;
    end else if (CE_I) begin
      unique case (bus_r)
        ccw_pkg::BUS_IDLE: begin
          if (take) begin
            bus_r <= ccw_pkg::BUS_ANSWER;
            waitreq_r <= 1'b0;
          end
        end
        ccw_pkg::BUS_ANSWER: begin
          bus_r <= ccw_pkg::BUS_IDLE;
          waitreq_r <= 1'b1;
        end
        default: begin
          bus_r <= ccw_pkg::BUS_IDLE;
          waitreq_r <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      cw0_r <= ccw_pkg::CW0_RESET;
      mask_r <= ccw_pkg::MASK_RESET;
      frame_addr_r <= ccw_pkg::FRAME_ADDR_RESET;
      word_cnt_r <= ccw_pkg::WORD_CNT_RESET;
    end else if (wr_ok) begin
      unique case (AVS_ADDRESS_I)
        ccw_pkg::ADDR_CW0: cw0_r <= cw0_nxt;
        ccw_pkg::ADDR_MASK: mask_r <= (mask_r & ~lane_mask) | (AVS_WRITEDATA_I & lane_mask);
        ccw_pkg::ADDR_FRAME_ADDR: frame_addr_r <= AVS_WRITEDATA_I[23:0];
        ccw_pkg::ADDR_WORD_CNT: word_cnt_r <= AVS_WRITEDATA_I;
        default: ;
      endcase
    end
  end

  // Frame data leaves as a one-cycle strobe
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      fdata_r <= 32'h00000000;
      fvalid_r <= 1'b0;
    end else if (CE_I) begin
      fvalid_r <= wr_ok & (AVS_ADDRESS_I == ccw_pkg::ADDR_FRAME_DATA);
      if (wr_ok & (AVS_ADDRESS_I == ccw_pkg::ADDR_FRAME_DATA)) begin
        fdata_r <= AVS_WRITEDATA_I;
      end
    end
  end

  // ----------------------------------------------------------------
  // Key latch and deferred security level
  // ----------------------------------------------------------------
  // The key choice is the bit 31 value held before the write that turns the decryptor on; later
  // writes to bit 31 are stored and readable but reach the key mux only once the decryptor is off.
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      key_eff_r <= 1'b0;
    end else if (CE_I & ~cw0_r.decryptor_enable) begin
      key_eff_r <= cw0_r.key_source_select;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      level_eff_r <= ccw_pkg::LEVEL_OPEN;
      eos_prev_r <= 1'b0;
    end else if (CE_I) begin
      eos_prev_r <= END_OF_STARTUP_I;
      if (load_level) begin
        level_eff_r <= cw0_r.security_level;
      end
    end
  end

  // Refusal flag: a new refusal wins over the read that clears it
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      refused_r <= 1'b0;
    end else if (CE_I) begin
      if (take & ((AVS_WRITE_I & wr_block) | (AVS_READ_I & rd_block))) begin
        refused_r <= 1'b1;
      end else if (take & AVS_READ_I & (AVS_ADDRESS_I == ccw_pkg::ADDR_STATUS)) begin
        refused_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 32'h00000000;
    status_word[ccw_pkg::STAT_KEY_POS] = key_eff_r;
    status_word[ccw_pkg::STAT_LEVEL_POS +: 2] = level_eff_r;
    status_word[ccw_pkg::STAT_OVERHEAT_POS] = overheat_s;
    status_word[ccw_pkg::STAT_CFG_TRI_POS] = cfg_tri_n_s;
    status_word[ccw_pkg::STAT_REFUSED_POS] = refused_r;
    unique case (AVS_ADDRESS_I)
      ccw_pkg::ADDR_CW0: rd_value = cw0_r & ccw_pkg::CW0_WRITABLE;
      ccw_pkg::ADDR_MASK: rd_value = mask_r;
      ccw_pkg::ADDR_FRAME_ADDR: rd_value = {8'h00, frame_addr_r};
      ccw_pkg::ADDR_WORD_CNT: rd_value = cw0_r.decryptor_enable ? 32'h00000000 : word_cnt_r;
      ccw_pkg::ADDR_STATUS: rd_value = status_word;
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      rdata_r <= 32'h00000000;
    end else if (take) begin
      rdata_r <= (AVS_READ_I & ~rd_block) ? rd_value : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      KEY_SOURCE_SELECT_O <= 1'b0;
      INTERNAL_PORT_SELECT_O <= 1'b0;
      OVERHEAT_POWER_DOWN_O <= 1'b0;
      FALLBACK_DISABLE_O <= 1'b0;
      READBACK_CELL_MASK_N_O <= 1'b1;
      FRAME_ADDR_VIEW_O <= 24'h000000;
      DECRYPTOR_ENABLE_O <= 1'b0;
      SECURITY_LEVEL_O <= ccw_pkg::LEVEL_OPEN;
      KEEP_CONFIG_PORT_O <= 1'b0;
      USER_GLOBAL_TRISTATE_N_O <= 1'b1;
      PULLUP_OFF_O <= 1'b0;
    end else if (CE_I) begin
      KEY_SOURCE_SELECT_O <= cw0_r.decryptor_enable ? key_eff_r :
        cw0_r.key_source_select;
      INTERNAL_PORT_SELECT_O <= cw0_r.internal_port_select;
      OVERHEAT_POWER_DOWN_O <= cw0_r.overheat_shutdown_enable & overheat_s;
      FALLBACK_DISABLE_O <= cw0_r.fallback_disable;
      READBACK_CELL_MASK_N_O <= cw0_r.readback_cell_mask_n;
      FRAME_ADDR_VIEW_O <= cw0_r.frame_addr_view_select ? READBACK_CRC_ADDR_I :
        ECC_ERROR_FRAME_ADDR_I;
      DECRYPTOR_ENABLE_O <= cw0_r.decryptor_enable;
      SECURITY_LEVEL_O <= level_eff_r;
      KEEP_CONFIG_PORT_O <= cw0_r.keep_config_port;
      USER_GLOBAL_TRISTATE_N_O <= cw0_r.user_global_tristate_n;
      PULLUP_OFF_O <= ~cw0_r.user_global_tristate_n & ~cfg_tri_n_s;
    end
  end

  assign AVS_READDATA_O = rdata_r;
  assign AVS_WAITREQUEST_O = waitreq_r;
  assign FRAME_DATA_O = fdata_r;
  assign FRAME_DATA_VALID_O = fvalid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reserved_zero_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (cw0_r & ~ccw_pkg::CW0_WRITABLE) == 32'h00000000)
    else $error("reserved control bit set");

  mask_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (wr_ok && AVS_ADDRESS_I == ccw_pkg::ADDR_CW0) |=>
      ((cw0_r ^ $past(cw0_r)) & ~$past(eff_mask)) == 32'h00000000)
    else $error("masked-out control bit changed");

  mask_apply_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (wr_ok && AVS_ADDRESS_I == ccw_pkg::ADDR_CW0) |=>
      (cw0_r & $past(eff_mask)) ==
      ($past(AVS_WRITEDATA_I) & $past(eff_mask) & ccw_pkg::CW0_WRITABLE))
    else $error("masked-in control bit not written");

  key_fixed_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (cw0_r.decryptor_enable && CE_I) ##1 cw0_r.decryptor_enable |->
      KEY_SOURCE_SELECT_O == key_eff_r && $stable(key_eff_r))
    else $error("key source moved while decryptor on");

  level_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    !load_level |=> $stable(level_eff_r))
    else $error("security level changed without stream end");

  ext_read_block_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && AVS_READ_I && ext && level_eff_r != ccw_pkg::LEVEL_OPEN) |=>
      AVS_READDATA_O == 32'h00000000 && !AVS_WAITREQUEST_O)
    else $error("external read not blocked");

  int_read_ok_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && AVS_READ_I && !ext && AVS_ADDRESS_I == ccw_pkg::ADDR_CW0) |=>
      AVS_READDATA_O == cw0_r)
    else $error("internal read restricted");

  enc_write_block_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && AVS_WRITE_I && ext && acc.encrypted &&
      AVS_ADDRESS_I == ccw_pkg::ADDR_CW0) |=> $stable(cw0_r))
    else $error("encrypted write reached control word");

  count_hidden_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    (take && AVS_READ_I && AVS_ADDRESS_I == ccw_pkg::ADDR_WORD_CNT &&
      cw0_r.decryptor_enable) |=> AVS_READDATA_O == 32'h00000000)
    else $error("word count visible with decryptor on");

  pullup_off_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    CE_I |=> PULLUP_OFF_O ==
      ($past(~cw0_r.user_global_tristate_n) && $past(~cfg_tri_n_s)))
    else $error("pull-up control wrong");

  answer_time_a: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
    take |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
    else $error("bus answer timing wrong");

endmodule : ccw_control_word

/* verif/ccw_src_model.sv */
`timescale 1ns/1ps
module ccw_src_model (
  // Clock
  input wire logic clk_i,
  // Avalon-MM master
  output logic [4:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  input wire logic [31:0] readdata_i,
  input wire logic waitrequest_i,
  // Access qualifiers
  output ccw_pkg::ccw_access_t acc_o
);
  // ----------------------------------------------------------------
  // Idle bus
  // ----------------------------------------------------------------
  initial begin
    address_o = 5'h1f;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'ha5a5a5a5;
    byteenable_o = 4'h0;
    acc_o = 2'h0;
  end

  // ----------------------------------------------------------------
  // One access; held until waitrequest is seen low at a rising edge
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, input ccw_pkg::ccw_access_t q,
                      output logic [31:0] rd);
    @(posedge clk_i);
    read_o <= ~wr;
    write_o <= wr;
    address_o <= a;
    writedata_o <= d;
    byteenable_o <= be;
    acc_o <= q;
    do @(posedge clk_i); while (waitrequest_i !== 1'b0);
    rd = readdata_i;
    // Released lines show inverted data so stale values cannot pass
    read_o <= 1'b0;
    write_o <= 1'b0;
    address_o <= ~a;
    writedata_o <= ~d;
    byteenable_o <= ~be;
  endtask : xfer
endmodule : ccw_src_model

/* verif/ccw_control_word_tb.sv */
`timescale 1ns/1ps
module ccw_control_word_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [23:0] ECC_A = 24'h5a5a5a;
  localparam logic [23:0] CRC_A = 24'h3c3c3c;
  localparam ccw_pkg::ccw_access_t EXT = 2'h0;
  localparam ccw_pkg::ccw_access_t INT = 2'h2;
  localparam ccw_pkg::ccw_access_t ENC = 2'h1;
  logic clk, rst, end_of_startup, enc_end, cfg_tri_n, wreq, rd_s, wr_s, fd_v;
  logic key, ips, ovh, fall, rcm, dec, keep, utri, pull;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, fd, fd_last;
  logic [3:0] be;
  logic [23:0] fav;
  logic [1:0] lvl;
  ccw_pkg::ccw_access_t acc;
  int error_cnt, n_compared, cyc, fd_cnt;

  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] wd;
    logic [3:0] be;
    logic [31:0] exp;
  } ccw_row_t;
  ccw_row_t rows [6] = '{
    '{32'hffffffff, 32'hffffffbf, 4'hf, 32'hc00015b9},
    '{32'h00000001, 32'h00000000, 4'hf, 32'hc00015b8},
    '{32'h0000ffff, 32'h00000000, 4'hf, 32'hc0000000},
    '{32'hffffffff, 32'h000015b9, 4'h1, 32'hc00000b9},
    '{32'h00001000, 32'hffffffff, 4'hf, 32'hc00010b9},
    '{32'hffffffff, 32'h00000101, 4'hf, 32'h00000101}};

  // ----------------------------------------------------------------
  // Design, far side and clock
  // ----------------------------------------------------------------
  ccw_control_word DUT (.CORE_CLK_I(clk), .RESET_I(rst), .CE_I(1'b1),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_s), .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
    .CFG_SRC_INTERNAL_I(acc.internal_port), .CFG_ENCRYPTED_I(acc.encrypted),
    .END_OF_STARTUP_I(end_of_startup), .ENC_STREAM_END_I(enc_end), .ECC_ERROR_FRAME_ADDR_I(ECC_A),
    .READBACK_CRC_ADDR_I(CRC_A), .OVERHEAT_ALARM_I(1'b1), .CFG_GLOBAL_TRISTATE_N_I(cfg_tri_n),
    .KEY_SOURCE_SELECT_O(key), .INTERNAL_PORT_SELECT_O(ips), .OVERHEAT_POWER_DOWN_O(ovh),
    .FALLBACK_DISABLE_O(fall), .READBACK_CELL_MASK_N_O(rcm), .FRAME_ADDR_VIEW_O(fav),
    .DECRYPTOR_ENABLE_O(dec), .SECURITY_LEVEL_O(lvl), .KEEP_CONFIG_PORT_O(keep),
    .USER_GLOBAL_TRISTATE_N_O(utri), .PULLUP_OFF_O(pull), .FRAME_DATA_O(fd),
    .FRAME_DATA_VALID_O(fd_v));
  ccw_src_model src (.clk_i(clk), .address_o(addr), .read_o(rd_s), .write_o(wr_s),
    .writedata_o(wdata), .byteenable_o(be), .readdata_i(rdata), .waitrequest_i(wreq),
    .acc_o(acc));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf,
                    input ccw_pkg::ccw_access_t q = 2'h0);
    logic [31:0] junk;
    src.xfer(1'b1, a, d, b, q, junk);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input ccw_pkg::ccw_access_t q,
                        input logic [31:0] exp);
    logic [31:0] v;
    src.xfer(1'b0, a, 32'h0, 4'hf, q, v);
    chk(v, exp);
  endtask : rd_chk

  task automatic chk_outs(input logic [31:0] e);
    chk({24'h0, key, ips, ovh, fall, rcm, dec, keep, utri},
        {24'h0, e[31], e[30], e[12], e[10], e[8], e[6], e[3], e[0]});
    chk({8'h0, fav}, {8'h0, (e[7] ? CRC_A : ECC_A)});
    chk({31'h0, pull}, {31'h0, ~e[0]});
  endtask : chk_outs

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Frame data pulses and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (fd_v === 1'b1) begin
      fd_cnt++;
      fd_last = fd;
    end
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    end_of_startup = 1'b0;
    enc_end = 1'b0;
    cfg_tri_n = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    fd_cnt = 0;
    do_reset();
    for (int i = 0; i < 6; i++) begin
      wr(ccw_pkg::ADDR_MASK, rows[i].mask);
      wr(ccw_pkg::ADDR_CW0, rows[i].wd, rows[i].be);
      rd_chk(ccw_pkg::ADDR_CW0, EXT, rows[i].exp);
      rd_chk(ccw_pkg::ADDR_MASK, EXT, rows[i].mask);
      chk_outs(rows[i].exp);
      $display("row %0d done", i);
    end
    // Locked level is deferred to startup end, then blocks the outer port only
    wr(ccw_pkg::ADDR_CW0, 32'hffffffbf);
    chk({30'h0, lvl}, 32'h0);
    @(posedge clk);
    end_of_startup <= 1'b1;
    repeat (3) @(posedge clk);
    end_of_startup <= 1'b0;
    chk({30'h0, lvl}, 32'h3);
    rd_chk(ccw_pkg::ADDR_CW0, EXT, 32'h0);
    // Status: key 1, level 3, alarm high, refusal flag set by the read above
    rd_chk(ccw_pkg::ADDR_STATUS, INT, 32'h0000002f);
    wr(ccw_pkg::ADDR_CW0, 32'h00000101);
    rd_chk(ccw_pkg::ADDR_CW0, INT, 32'hc00015b9);
    wr(ccw_pkg::ADDR_CW0, 32'h40000000, 4'hf, INT);
    rd_chk(ccw_pkg::ADDR_CW0, INT, 32'h40000000);
    do_reset();
    chk({30'h0, lvl}, 32'h0);
    chk_outs(32'h00000101);
    rd_chk(ccw_pkg::ADDR_CW0, EXT, 32'h00000101);
    rd_chk(ccw_pkg::ADDR_MASK, EXT, 32'hffffffff);
    $display("test lock and reset done");
    // Key freeze, word count hiding, encrypted stream
    wr(ccw_pkg::ADDR_WORD_CNT, 32'h12345678);
    rd_chk(ccw_pkg::ADDR_WORD_CNT, EXT, 32'h12345678);
    wr(ccw_pkg::ADDR_CW0, 32'h80000101);
    wr(ccw_pkg::ADDR_CW0, 32'h80000151);
    wr(ccw_pkg::ADDR_CW0, 32'h00000151);
    rd_chk(ccw_pkg::ADDR_CW0, EXT, 32'h00000151);
    chk({31'h0, key}, 32'h1);
    rd_chk(ccw_pkg::ADDR_WORD_CNT, EXT, 32'h0);
    @(posedge clk);
    end_of_startup <= 1'b1;
    repeat (3) @(posedge clk);
    end_of_startup <= 1'b0;
    chk({30'h0, lvl}, 32'h0);
    enc_end <= 1'b1;
    @(posedge clk);
    enc_end <= 1'b0;
    repeat (2) @(posedge clk);
    chk({30'h0, lvl}, 32'h1);
    rd_chk(ccw_pkg::ADDR_CW0, EXT, 32'h0);
    rd_chk(ccw_pkg::ADDR_CW0, INT, 32'h00000151);
    wr(ccw_pkg::ADDR_CW0, 32'h00000101, 4'hf, ENC);
    rd_chk(ccw_pkg::ADDR_CW0, INT, 32'h00000151);
    wr(ccw_pkg::ADDR_FRAME_DATA, 32'hcafef00d, 4'hf, ENC);
    repeat (2) @(posedge clk);
    chk(fd_cnt, 32'h1);
    chk(fd_last, 32'hcafef00d);
    wr(ccw_pkg::ADDR_CW0, 32'h00000011);
    rd_chk(ccw_pkg::ADDR_CW0, INT, 32'h00000011);
    chk({31'h0, key}, 32'h0);
    $display("test decryptor done");
    print_verdict();
  end
endmodule : ccw_control_word_tb
